/* hdl/bocfg_decode.sv */
// Purpose: Splits the latched option word into its fields
// Assumes: Word is stable between resets
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "bocfg_map.svh"
module bocfg_decode
(
  input  wire logic [7:0] word_in,
  bocfg_opt_if.src        opt
);

  // Base address per select code
  function automatic logic [15:0] base_of
  (
    input bocfg_pkg::bocfg_base_sel_t sel
  );
    case (sel)
      2'h0:    base_of = `BOCFG_BASE_SEL0;
      2'h1:    base_of = `BOCFG_BASE_SEL1;
      2'h2:    base_of = `BOCFG_BASE_SEL2;
      default: base_of = `BOCFG_BASE_NONE;
    endcase
  endfunction

  // Field split
  assign opt.guard_off    = word_in[`BOCFG_OPT_GUARD];
  assign opt.lvr_off      = word_in[`BOCFG_OPT_LVR];
  assign opt.base_sel     = {word_in[`BOCFG_OPT_BASE_HI],
                             word_in[`BOCFG_OPT_BASE_LO]};
  assign opt.base_addr    = base_of(opt.base_sel);
  assign opt.has_loader   = (opt.base_sel != 2'h3);
  assign opt.hw_boot_sel  = word_in[`BOCFG_OPT_POWERUP_BOOT_SELECT];
  assign opt.scramble_off = word_in[`BOCFG_OPT_SCRAMBLE];
  assign opt.lock_off     = word_in[`BOCFG_OPT_LOCK];

endmodule

/* hdl/bocfg_map.svh */
// Purpose: Offsets, field positions, reset values of the boot option block
// Assumes: Included by bare name; definitions only
// Notes:   Register index times four gives the Avalon byte address
//
// What this block does
// - Guard bit low blocks loader flash at low voltage
// - Reset-enable bit low resets on low voltage
// - Two-bit field picks loader base or none
// - Power-up boot select picks loader or application
// - Boot entrance follows active boot select only
// - Only power-up loads inverted boot select bit
// - Scramble bit low scrambles programmer code dump
// - Lock bit low forbids programmer code dump
// - No software write path to option word
`ifndef BOCFG_MAP_SVH
`define BOCFG_MAP_SVH

// Register indices (byte address = index * 4)
`define BOCFG_IDX_LDR_CTRL   8'hE7
`define BOCFG_IDX_STATUS     8'hF7
`define BOCFG_IDX_OPT_WORD   8'hF8

// Reset values
`define BOCFG_LDR_CTRL_RST   8'h00
`define BOCFG_OPT_WORD_RST   8'hFF

// Option word field positions
`define BOCFG_OPT_GUARD      7
`define BOCFG_OPT_LVR        6
`define BOCFG_OPT_BASE_HI    5
`define BOCFG_OPT_BASE_LO    4
`define BOCFG_OPT_POWERUP_BOOT_SELECT       3
`define BOCFG_OPT_RSVD       2
`define BOCFG_OPT_SCRAMBLE   1
`define BOCFG_OPT_LOCK       0

// Loader control field positions
`define BOCFG_LC_ENABLE      7
`define BOCFG_LC_BOOT_SEL    6
`define BOCFG_LC_SW_RESET    5
`define BOCFG_LC_FAIL        4
`define BOCFG_LC_WAIT_HI     2
`define BOCFG_LC_WAIT_LO     0

// Loader region bases
`define BOCFG_BASE_SEL0      16'h3000
`define BOCFG_BASE_SEL1      16'h3400
`define BOCFG_BASE_SEL2      16'h3800
`define BOCFG_BASE_NONE      16'h0000

`endif

/* hdl/bocfg_opt_if.sv */
// Purpose: Decoded option fields between decoder and top
// Assumes: One decoder drives, the top reads
// Notes:   Plain wires, no timing of its own
`timescale 1ns/1ps
interface bocfg_opt_if;
  logic                     guard_off;    // High: no low-voltage block
  logic                     lvr_off;      // High: no low-voltage reset
  bocfg_pkg::bocfg_base_sel_t base_sel;   // Loader base select
  logic                     has_loader;   // Loader region exists
  logic [15:0]              base_addr;    // Loader region base
  logic                     hw_boot_sel;  // Power-up boot select
  logic                     scramble_off; // High: dump transparent
  logic                     lock_off;     // High: dump permitted

  modport src (output guard_off, lvr_off, base_sel, has_loader,
               base_addr, hw_boot_sel, scramble_off, lock_off);
  modport dst (input guard_off, lvr_off, base_sel, has_loader,
               base_addr, hw_boot_sel, scramble_off, lock_off);
endinterface

/* hdl/bocfg_pkg.sv */
// Purpose: Types of the boot option block
// Assumes: Used by scoped names only
// Notes:   Numbers live in bocfg_map.svh
package bocfg_pkg;

  // Boot sequencer states
  typedef enum logic [1:0]
  {
    BOCFG_S_COLD,
    BOCFG_S_WARM,
    BOCFG_S_HOLD,
    BOCFG_S_RUN
  } bocfg_state_t;

  // Loader base select field
  typedef logic [1:0] bocfg_base_sel_t;

endpackage

/* hdl/bocfg_top.sv */
// Purpose: Boot option loader with loader control register
// Assumes: Inputs synchronous to CLK_SYS_IN; RST_N_IN is power-up
// Notes:   Registers over Avalon-MM, one wait cycle per access
`timescale 1ns/1ps
`include "bocfg_map.svh"
module bocfg_top
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic [7:0]  OPT_WORD_IN,
  input  wire logic        PIN_RESET_IN,
  input  wire logic        LOWVOLT_IN,
  input  wire logic        FLASH_FAIL_IN,
  input  wire logic [9:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic      [31:0] AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  output logic             CORE_RESET_OUT,
  output logic             BOOT_START_OUT,
  output logic             BOOT_TO_LOADER_OUT,
  output logic             FLASH_GUARD_BLOCK_OUT,
  output logic             LOWVOLT_RESET_OUT,
  output logic             LOADER_PRESENT_OUT,
  output logic      [15:0] LOADER_BASE_OUT,
  output logic             DUMP_SCRAMBLE_OUT,
  output logic             DUMP_LOCK_OUT
);

  //////////////////////////////////////////////////////////////////////
  // Declarations
  //////////////////////////////////////////////////////////////////////

  bocfg_pkg::bocfg_state_t state_q;   // Boot sequencer
  bocfg_pkg::bocfg_state_t state_d;   // Next sequencer state

  logic [7:0]  opt_word_q;   // Latched option word
  logic        ld_enable_q;  // Loader control enable bit
  logic        boot_sel_q;   // Active boot select bit
  logic        sw_reset_q;   // Software reset request
  logic        fail_q;       // Flash command failure flag
  logic [2:0]  wait_q;       // Flash wait setting
  logic        wait_req_q;   // Bus wait request
  logic [31:0] rdata_q;      // Bus read data
  logic        core_rst_q;   // Core held in reset
  logic        boot_go_q;    // Boot start pulse
  logic        to_loader_q;  // Boot entrance latch
  logic        guard_q;      // Flash access blocked
  logic        lv_rst_q;     // Low-voltage reset
  logic        present_q;    // Loader region exists
  logic [15:0] base_q;       // Loader region base
  logic        scramble_q;   // Dump scrambled
  logic        lock_q;       // Dump locked

  logic        bus_req;      // Any access pending
  logic        bus_take;     // Access completes now
  logic        wr_ctrl;      // Write to loader control
  logic        warm_cause;   // Pin, software or low-voltage reset
  logic [7:0]  ctrl_view;    // Loader control as read
  logic [7:0]  status_view;  // Status as read

  bocfg_opt_if opt ();       // Decoded option fields

  //////////////////////////////////////////////////////////////////////
  // Helpers
  //////////////////////////////////////////////////////////////////////

  // Address match against a register index
  function automatic logic hit
  (
    input logic [9:0] addr,
    input logic [7:0] idx
  );
    hit = (addr[9:2] == idx);
  endfunction

  // Field decoder of the latched word
  bocfg_decode u_decode
  (
    .word_in (opt_word_q),
    .opt     (opt)
  );

  //////////////////////////////////////////////////////////////////////
  // Bus decode
  //////////////////////////////////////////////////////////////////////

  // Read and write never overlap on a well-behaved master
  assign bus_req  = AVS_READ_IN | AVS_WRITE_IN;

  // Completion is the edge where waitrequest is seen low
  assign bus_take = bus_req & ~wait_req_q;

  // Only loader control accepts writes; option word has no path
  assign wr_ctrl  = bus_take & AVS_WRITE_IN &
                    AVS_BYTEENABLE_IN[0] &
                    hit(AVS_ADDRESS_IN, `BOCFG_IDX_LDR_CTRL);

  // Low-voltage reset counts as a warm boot cause
  assign warm_cause = PIN_RESET_IN | sw_reset_q |
                      (~opt.lvr_off & LOWVOLT_IN);

  // Loader control view, bit 3 reads zero
  assign ctrl_view = {ld_enable_q, boot_sel_q, sw_reset_q, fail_q,
                      1'b0, wait_q};

  // Status view: live state of the block
  assign status_view = {core_rst_q, to_loader_q, guard_q, lv_rst_q,
                        present_q, LOWVOLT_IN, state_q == 
                        bocfg_pkg::BOCFG_S_RUN, boot_go_q};

  //////////////////////////////////////////////////////////////////////
  // Bus slave
  //////////////////////////////////////////////////////////////////////

  // Waitrequest: high by default, low for one cycle to answer
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      wait_req_q <= 1'b1;
    end
    else
    begin
      // Low on the edge after a request is seen waiting, else high
      wait_req_q <= ~(bus_req & wait_req_q);
    end
  end

  // Read data prepared in the wait cycle
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (AVS_READ_IN && wait_req_q)
    begin
      if (hit(AVS_ADDRESS_IN, `BOCFG_IDX_LDR_CTRL))
      begin
        rdata_q <= {24'h00_0000, ctrl_view};
      end
      else if (hit(AVS_ADDRESS_IN, `BOCFG_IDX_OPT_WORD))
      begin
        rdata_q <= {24'h00_0000, opt_word_q};
      end
      else if (hit(AVS_ADDRESS_IN, `BOCFG_IDX_STATUS))
      begin
        rdata_q <= {24'h00_0000, status_view};
      end
      else
      begin
        // Unmapped reads return zero
        rdata_q <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Loader control register
  //////////////////////////////////////////////////////////////////////

  // Enable, wait and software reset: cleared by any boot, so a
  // software reset request is dropped once the boot has taken it
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ld_enable_q <= 1'(`BOCFG_LDR_CTRL_RST >> `BOCFG_LC_ENABLE);
      sw_reset_q  <= 1'(`BOCFG_LDR_CTRL_RST >> `BOCFG_LC_SW_RESET);
      wait_q      <= 3'(`BOCFG_LDR_CTRL_RST >> `BOCFG_LC_WAIT_LO);
    end
    else if (state_q != bocfg_pkg::BOCFG_S_RUN)
    begin
      ld_enable_q <= 1'b0;
      sw_reset_q  <= 1'b0;
      wait_q      <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      ld_enable_q <= AVS_WRITEDATA_IN[`BOCFG_LC_ENABLE];
      sw_reset_q  <= AVS_WRITEDATA_IN[`BOCFG_LC_SW_RESET];
      wait_q      <= AVS_WRITEDATA_IN[`BOCFG_LC_WAIT_HI:
                                      `BOCFG_LC_WAIT_LO];
    end
  end

  // Active boot select: seeded only on power-up, kept on warm boots
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      boot_sel_q <= 1'b0;
    end
    else if (state_q == bocfg_pkg::BOCFG_S_COLD)
    begin
      // Inverted power-up select, taken from OPT_WORD_IN as it is being latched
      boot_sel_q <= ~OPT_WORD_IN[`BOCFG_OPT_POWERUP_BOOT_SELECT];
    end
    else if (wr_ctrl)
    begin
      // Software may steer the next pin or software boot
      boot_sel_q <= AVS_WRITEDATA_IN[`BOCFG_LC_BOOT_SEL];
    end
  end

  // Failure flag: hardware sets, software clears by writing zero
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      fail_q <= 1'b0;
    end
    else if (FLASH_FAIL_IN)
    begin
      // Set wins over a clear in the same cycle
      fail_q <= 1'b1;
    end
    else if (wr_ctrl && !AVS_WRITEDATA_IN[`BOCFG_LC_FAIL])
    begin
      fail_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Option word latch
  //////////////////////////////////////////////////////////////////////

  // Sampled after each reset, never written by software
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      opt_word_q <= `BOCFG_OPT_WORD_RST;
    end
    else if (state_q == bocfg_pkg::BOCFG_S_COLD ||
             state_q == bocfg_pkg::BOCFG_S_WARM)
    begin
      opt_word_q <= OPT_WORD_IN;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Boot sequencer
  //////////////////////////////////////////////////////////////////////

  // Next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bocfg_pkg::BOCFG_S_COLD:
      begin
        // Word and boot select loaded this cycle
        state_d = bocfg_pkg::BOCFG_S_HOLD;
      end
      bocfg_pkg::BOCFG_S_WARM:
      begin
        // Word reloaded, boot select untouched
        state_d = bocfg_pkg::BOCFG_S_HOLD;
      end
      bocfg_pkg::BOCFG_S_HOLD:
      begin
        // Stay while a reset cause persists
        if (!warm_cause)
        begin
          state_d = bocfg_pkg::BOCFG_S_RUN;
        end
      end
      bocfg_pkg::BOCFG_S_RUN:
      begin
        if (warm_cause)
        begin
          state_d = bocfg_pkg::BOCFG_S_WARM;
        end
      end
      default:
      begin
        state_d = bocfg_pkg::BOCFG_S_COLD;
      end
    endcase
  end

  // State register; power-up always starts cold
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_q <= bocfg_pkg::BOCFG_S_COLD;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Core reset and boot pulse
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      core_rst_q  <= 1'b1;
      boot_go_q   <= 1'b0;
      to_loader_q <= 1'b0;
    end
    else
    begin
      core_rst_q <= (state_d != bocfg_pkg::BOCFG_S_RUN);
      boot_go_q  <= (state_q == bocfg_pkg::BOCFG_S_HOLD) &&
                    (state_d == bocfg_pkg::BOCFG_S_RUN);
      if (state_q == bocfg_pkg::BOCFG_S_HOLD)
      begin
        // Entrance from the active select alone, any cause
        to_loader_q <= boot_sel_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Configuration outputs
  //////////////////////////////////////////////////////////////////////

  // Low-voltage effects follow the supply live
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      guard_q  <= 1'b0;
      lv_rst_q <= 1'b0;
    end
    else
    begin
      guard_q  <= ~opt.guard_off & LOWVOLT_IN;
      lv_rst_q <= ~opt.lvr_off & LOWVOLT_IN;
    end
  end

  // Static fields copied from the latched word
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      present_q  <= 1'b0;
      base_q     <= `BOCFG_BASE_NONE;
      scramble_q <= 1'b0;
      lock_q     <= 1'b1;
    end
    else
    begin
      present_q  <= opt.has_loader;
      base_q     <= opt.base_addr;
      scramble_q <= ~opt.scramble_off;
      lock_q     <= ~opt.lock_off;
    end
  end

  // Ports straight from flip-flops
  assign AVS_READDATA_OUT      = rdata_q;
  assign AVS_WAITREQUEST_OUT   = wait_req_q;
  assign CORE_RESET_OUT        = core_rst_q;
  assign BOOT_START_OUT        = boot_go_q;
  assign BOOT_TO_LOADER_OUT    = to_loader_q;
  assign FLASH_GUARD_BLOCK_OUT = guard_q;
  assign LOWVOLT_RESET_OUT     = lv_rst_q;
  assign LOADER_PRESENT_OUT    = present_q;
  assign LOADER_BASE_OUT       = base_q;
  assign DUMP_SCRAMBLE_OUT     = scramble_q;
  assign DUMP_LOCK_OUT         = lock_q;

endmodule

/* testbench/bocfg_check_assertions.sv */
// Purpose: Port-level checks of the boot option block
// Assumes: Option word held steady across warm boots
// Notes:   Word copy taken at the first edge after power-up
`timescale 1ns/1ps
module bocfg_check
(
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_N_IN,
  input wire logic [7:0]  OPT_WORD_IN,
  input wire logic        PIN_RESET_IN,
  input wire logic        LOWVOLT_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic        AVS_WAITREQUEST_OUT,
  input wire logic        CORE_RESET_OUT,
  input wire logic        BOOT_START_OUT,
  input wire logic        BOOT_TO_LOADER_OUT,
  input wire logic        FLASH_GUARD_BLOCK_OUT,
  input wire logic        LOWVOLT_RESET_OUT,
  input wire logic        LOADER_PRESENT_OUT,
  input wire logic [15:0] LOADER_BASE_OUT,
  input wire logic        DUMP_SCRAMBLE_OUT,
  input wire logic        DUMP_LOCK_OUT
);
  logic       seen_q;  // Word copy taken
  logic       first_q; // First boot since power-up pending
  logic [7:0] word_q;  // Copy of the latched word

  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);

  ////////////////////////////////////////////////////////////////////////////
  // Copy once; later input changes must not reach the outputs
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      seen_q  <= 1'h0;
      first_q <= 1'h1;
    end
    else
    begin
      if (!seen_q)
        word_q <= OPT_WORD_IN;
      seen_q <= 1'h1;
      if (BOOT_START_OUT)
        first_q <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_base;
    !CORE_RESET_OUT |-> LOADER_PRESENT_OUT == (word_q[5:4] != 2'h3) &&
      LOADER_BASE_OUT == (word_q[5:4] == 2'h0 ? 16'h3000 :
      word_q[5:4] == 2'h1 ? 16'h3400 : word_q[5:4] == 2'h2 ? 16'h3800 :
      16'h0000);
  endproperty
  a_base: assert property (p_base)
    else $error("loader base mismatch");

  property p_dump;
    !CORE_RESET_OUT |-> DUMP_SCRAMBLE_OUT == !word_q[1] &&
      DUMP_LOCK_OUT == !word_q[0];
  endproperty
  a_dump: assert property (p_dump)
    else $error("dump control mismatch");

  property p_guard;
    !CORE_RESET_OUT && LOWVOLT_IN && word_q[6] |=>
      FLASH_GUARD_BLOCK_OUT == !word_q[7] && !CORE_RESET_OUT;
  endproperty
  a_guard: assert property (p_guard)
    else $error("flash guard wrong at low voltage");

  property p_lvr;
    !CORE_RESET_OUT && LOWVOLT_IN && !word_q[6] |=>
      CORE_RESET_OUT && LOWVOLT_RESET_OUT;
  endproperty
  a_lvr: assert property (p_lvr)
    else $error("low voltage reset missing");

  property p_cause;
    FLASH_GUARD_BLOCK_OUT || LOWVOLT_RESET_OUT |-> $past(LOWVOLT_IN) &&
      (!FLASH_GUARD_BLOCK_OUT || !word_q[7]) &&
      (!LOWVOLT_RESET_OUT || !word_q[6]);
  endproperty
  a_cause: assert property (p_cause)
    else $error("low voltage action without cause");

  property p_pulse;
    BOOT_START_OUT |-> $past(CORE_RESET_OUT) && !CORE_RESET_OUT
      ##1 !BOOT_START_OUT;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("boot start pulse malformed");

  property p_powerup;
    BOOT_START_OUT && first_q |-> BOOT_TO_LOADER_OUT == !word_q[3];
  endproperty
  a_powerup: assert property (p_powerup)
    else $error("power-up boot entrance wrong");

  property p_pin;
    !CORE_RESET_OUT && PIN_RESET_IN |=> CORE_RESET_OUT;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin reset not taken");

  property p_stable;
    !CORE_RESET_OUT && $past(!CORE_RESET_OUT) |->
      $stable(LOADER_BASE_OUT) && $stable(DUMP_LOCK_OUT);
  endproperty
  a_stable: assert property (p_stable)
    else $error("configuration changed while running");

  property p_wait;
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=>
      !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT;
  endproperty
  a_wait: assert property (p_wait)
    else $error("bus answer timing wrong");
endmodule

bind bocfg_top bocfg_check u_check (.CLK_SYS_IN, .RST_N_IN, .OPT_WORD_IN,
  .PIN_RESET_IN, .LOWVOLT_IN, .AVS_READ_IN, .AVS_WRITE_IN,
  .AVS_WAITREQUEST_OUT, .CORE_RESET_OUT, .BOOT_START_OUT, .BOOT_TO_LOADER_OUT,
  .FLASH_GUARD_BLOCK_OUT, .LOWVOLT_RESET_OUT, .LOADER_PRESENT_OUT,
  .LOADER_BASE_OUT, .DUMP_SCRAMBLE_OUT, .DUMP_LOCK_OUT);

/* testbench/bocfg_test.sv */
// Purpose: Self-checking bench of the boot option block
// Assumes: Master waits for waitrequest low, byte enables all set
// Notes:   Word only changed in reset, or briefly to probe latching
`timescale 1ns/1ps
module bocfg_test;
  logic        clk, rst_n, pin_rst, lowvolt, fail_in, rd, wr, sel;
  logic        waitreq, core_rst, boot_start, to_ldr, guard, lvr;
  logic        present, scr, lock;
  logic [7:0]  word, w, got;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata, rnd;
  logic [15:0] base;
  int          fails, checks_done;

  bocfg_top dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .OPT_WORD_IN(word),
    .PIN_RESET_IN(pin_rst), .LOWVOLT_IN(lowvolt), .FLASH_FAIL_IN(fail_in),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
    .CORE_RESET_OUT(core_rst), .BOOT_START_OUT(boot_start),
    .BOOT_TO_LOADER_OUT(to_ldr), .FLASH_GUARD_BLOCK_OUT(guard),
    .LOWVOLT_RESET_OUT(lvr), .LOADER_PRESENT_OUT(present),
    .LOADER_BASE_OUT(base), .DUMP_SCRAMBLE_OUT(scr), .DUMP_LOCK_OUT(lock));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Loader base expected from the two select bits
  function automatic logic [15:0] exp_base(input logic [7:0] v);
    case (v[5:4])
      2'h0: return 16'h3000;
      2'h1: return 16'h3400;
      2'h2: return 16'h3800;
      default: return 16'h0000;
    endcase
  endfunction

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      fails = fails + 1;
    end
  endtask

  task complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Request held until waitrequest is sampled low
  task bus(input logic we, input logic [9:0] a, input logic [7:0] d,
           output logic [7:0] q);
    addr <= a;
    wr <= we;
    rd <= !we;
    wdata <= {rnd[31:8], d};
    // No cycle count assumed; only the watchdog ends this wait
    do
      @(posedge clk);
    while (waitreq !== 1'h0);
    q = rdata[7:0];
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge clk);
  endtask

  // Bounded wait for the core to leave reset
  task wait_boot;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n = n + 1;
    end
    while (boot_start !== 1'h1 && n < 50);
    if (n >= 50)
    begin
      fails = fails + 1;
      complete_run;
    end
  endtask

  task powerup(input logic [7:0] v);
    rst_n <= 1'h0;
    word <= v;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    wait_boot;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: far beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    complete_run;
  end

  initial
  begin
    {clk, pin_rst, lowvolt, fail_in, rd, wr} = 6'h00;
    rst_n = 1'h0;
    word = 8'hFF;
    addr = 10'h000;
    wdata = 32'h00000000;
    fails = 0;
    checks_done = 0;
    rnd = 32'h1B9E;
    // Every loader base select, reserved bit kept set, reset-enable bit from i, other bits random
    for (int i = 0; i < 4; i++)
    begin
      rnd = xs(rnd);
      // Reset-enable bit alternates so both low-voltage paths run
      w = {rnd[7], i[0], i[1:0], rnd[3], 1'h1, rnd[1:0]};
      powerup(w);
      check(to_ldr, !w[3]);
      check(base, exp_base(w));
      check(present, w[5:4] != 2'h3);
      check(scr, !w[1]);
      check(lock, !w[0]);
      bus(1'h1, 10'h3E0, ~w, got);
      bus(1'h0, 10'h3E0, 8'h00, got);
      check(got, w);
      bus(1'h0, 10'h39C, 8'h00, got);
      check(got[6], !w[3]);
      bus(1'h0, 10'h100, 8'h00, got);
      check(got, 16'h0000);
      // Status: running, entrance and loader presence, no low voltage
      bus(1'h0, 10'h3DC, 8'h00, got);
      check(got, {1'h0, !w[3], 2'h0, w[5:4] != 2'h3, 3'h2});
      // Input change while running must not reach the outputs
      word <= ~w;
      repeat (3) @(posedge clk);
      check(base, exp_base(w));
      check(lock, !w[0]);
      word <= w;
      lowvolt <= 1'h1;
      repeat (3) @(posedge clk);
      check(guard, !w[7]);
      check(lvr, !w[6]);
      check(core_rst, !w[6]);
      lowvolt <= 1'h0;
      if (!w[6])
      begin
        wait_boot;
        check(to_ldr, !w[3]);
      end
      // Pin boot follows the written select bit
      sel = rnd[9];
      bus(1'h1, 10'h39C, {1'h0, sel, 6'h00}, got);
      pin_rst <= 1'h1;
      @(posedge clk);
      pin_rst <= 1'h0;
      wait_boot;
      check(to_ldr, sel);
      // Software boot with the select flipped in the same write
      bus(1'h1, 10'h39C, {1'h1, !sel, 6'h25}, got);
      wait_boot;
      check(to_ldr, !sel);
      fail_in <= 1'h1;
      @(posedge clk);
      fail_in <= 1'h0;
      bus(1'h0, 10'h39C, 8'h00, got);
      check(got, {1'h0, !sel, 6'h10});
    end
    complete_run;
  end
endmodule
